// File: iap_flash_write_buffer_regs.v
// What this block does
// [R1] Buffer loads only after erase/write enabled
// [R2] Clear bit runs clear, hardware drops it
// [R3] Software clears buffer before first use
// [R4] 32-word buffer mapped by page bits
// [R5] First low byte write only stores register
// [R6] First high byte write loads word, increments
// [R7] Address holds at last in-page word
// [R8] Finished flash write clears buffer automatically
// [R9] Software clears and reloads after bad verify
// [R10] 13-bit address, high reg bits 7-5 zero
// [R11] Two address, four data pairs, three controls
// [R12] Address, data registers read/write, reset zero
// [R13] Mode field: write, erase, read, enable
// [R14] Enabled status set by hardware, zero disables
// [R15] Write start set by software, hardware clears
// [R16] Disabled high byte write leaves buffer alone
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "iap_map.vh"

////////////////////////////////////////////////////////////////////////////
// Register map, one byte per aligned word:
//   main control, reset pattern, buffer control,
//   address low, address high, then four data pairs,
//   each pair with its low byte first and its high byte second.
// Only bits 7:0 of a word carry data; the rest read as zero.
// Unmapped words answer with an error and change nothing.
// The flash sequencing logic (enable procedure, erase, write and
// read timing) sits outside this block and talks to it through
// the pulse inputs and the status outputs below.
module iap_flash_write_buffer_regs #(
   parameter AW = 12
) (
   input  wire          ref_clk,
   input  wire          resetn,
   // APB slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [AW-1:0] paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   // Flash sequencing logic, same clock
   input  wire          ew_enable_success,  // Enable procedure passed
   input  wire          enable_timer_expired,
   input  wire          flash_write_done,
   input  wire          flash_read_done,
   input  wire [4:0]    buf_rd_index,
   output wire [15:0]   buf_rd_data,
   output wire [2:0]    operation_mode_field,
   output wire          write_start_flag,
   output wire          read_enable_bit,
   output wire          read_start_flag,
   output wire          enable_procedure_trigger,
   output wire          erase_write_enabled_status,
   output wire [7:0]    page_select_bits,
   output wire [12:0]   flash_address,
   output wire [7:0]    reset_pattern_register,
   output wire          buffer_clear_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   reg        ew_enabled_q;              // Erase/write enabled status
   reg [2:0]  mode_q;                    // Operation mode field
   reg        enable_trig_q;             // Enable procedure running
   reg        write_start_q;             // Write in progress
   reg        read_enable_q;             // Read function enabled
   reg        read_start_q;              // Read in progress
   reg [7:0]  reset_pattern_q;           // Chip reset pattern byte
   reg [7:0]  address_low_byte;          // Flash address 7..0
   reg [4:0]  address_high_byte;         // Flash address 12..8
   reg [7:0]  data_low_q  [0:3];         // Data pair low bytes
   reg [7:0]  data_high_q [0:3];         // Data pair high bytes
   integer    k;

   wire       clear_busy;                // Buffer sweep running
   wire       wr_access;                 // Write taken this edge
   wire       rd_setup;                  // Read setup cycle
   wire       mapped;                    // Address decodes
   wire [7:0] wbyte;                     // Written byte
   wire       wr_first_high;             // First high byte written
   wire       buffer_load;               // Word goes into buffer
   wire       buffer_clear_request;      // Start a clear sweep
   wire [7:0] first_data_low_byte;
   wire [7:0] first_data_high_byte;

   assign wbyte     = pwdata[7:0];
   assign mapped    = reg_hit(paddr);
   assign wr_access = psel & penable & pwrite & mapped;
   assign rd_setup  = psel & ~penable & ~pwrite;

   ////////////////////////////////////////////////////////////////////////////
   // Decode: true for any implemented register word
   // Byte lanes other than the lowest are not supported, so an
   // unaligned address is treated as unmapped rather than being
   // silently folded onto a neighbouring register.
   function reg_hit;
      input [AW-1:0] a;
      begin
         reg_hit = (a[1:0] == 2'h0) && (a <= `OFS_DATA3_HIGH);  // see [R11]
      end
   endfunction

   // Index of a data pair from its offset (pairs start at data0 low)
   function [1:0] pair_of;
      input [AW-1:0] a;
      reg   [AW-1:0] rel;
      begin
         rel     = a - `OFS_DATA0_LOW;
         pair_of = rel[4:3];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB answers: zero wait states, unmapped words flag an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Buffer side effects of a first high byte write
   assign first_data_low_byte  = data_low_q[0];
   assign first_data_high_byte = data_high_q[0];
   assign wr_first_high = wr_access && (paddr == `OFS_DATA0_HIGH);
   // Loads are refused until erase/write has been enabled
   assign buffer_load = wr_first_high & ew_enabled_q;  // see [R1] see [R16]
   // Software request or a finished flash write both start a sweep
   assign buffer_clear_request = (wr_access && (paddr == `OFS_BUFFER_CTRL)
                                  && wbyte[`BIT_BUFFER_CLEAR])
                                 | flash_write_done;  // see [R2] see [R8]

   // The buffer is a separate module so that its clear sweep and its
   // read port towards the programming logic stay out of the register
   // decode. A clear costs one cycle per word; software sees the clear
   // bit high for the whole sweep and must wait for it to drop.
   write_page_buffer #(
      .DEPTH  (`PAGE_WORDS),
      .IDX_W  (`WORD_IDX_W),
      .WORD_W (16)
   ) u_buf (
      .ref_clk     (ref_clk),
      .resetn      (resetn),
      .load_valid  (buffer_load),
      // Word slot comes from the in-page address bits
      .load_index  (address_low_byte[`WORD_IDX_W-1:0]),  // see [R4]
      // Freshly written high byte joins the stored low byte
      .load_word   ({wbyte, first_data_low_byte}),  // see [R6] see [R5]
      .clear_start (buffer_clear_request),
      .clear_busy  (clear_busy),
      .rd_index    (buf_rd_index),
      .rd_data     (buf_rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Flash address pair, with in-page auto increment
   // The increment is confined to the in-page bits, so a run of word
   // commits can never spill into the next page. Once the last word of
   // the page is reached, software has to load a new page address.
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         address_low_byte  <= `RST_BYTE;  // see [R12]
         address_high_byte <= 5'h00;
      end else if (wr_access && paddr == `OFS_ADDR_LOW) begin
         address_low_byte <= wbyte;
      end else if (wr_access && paddr == `OFS_ADDR_HIGH) begin
         // Only five bits exist above the low byte
         address_high_byte <= wbyte[`ADDR_HIGH_BITS-1:0];  // see [R10]
      end else if (wr_first_high) begin
         // Tagging also advances during erase; stops on the page's last word
         if (address_low_byte[`WORD_IDX_W-1:0] != `LAST_WORD_IDX) begin
            address_low_byte <= address_low_byte + 8'h01;  // see [R6]
         end  // see [R7]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data register pairs: plain storage
   // Pairs one to three are only stored and read back over APB; no output
   // carries them, and only the first pair feeds the write buffer.
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (k = 0; k < 4; k = k + 1) begin
            data_low_q[k]  <= `RST_BYTE;  // see [R12]
            data_high_q[k] <= `RST_BYTE;
         end
      end else if (wr_access && paddr >= `OFS_DATA0_LOW) begin
         // Low byte of a pair stores only; no buffer action here
         if (paddr[2] == 1'b1) begin
            data_low_q[pair_of(paddr)] <= wbyte;  // see [R5]
         end else begin
            data_high_q[pair_of(paddr)] <= wbyte;  // see [R16]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main control register; hardware sets win over same-cycle clears
   // The status bit is deliberately one-way from software: a stray write
   // of one must never unlock erase/write, while writing zero is the
   // safe direction and takes effect unless ew_enable_success fires in the same cycle.
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ew_enabled_q    <= 1'b0;
         mode_q          <= `MODE_WRITE;
         enable_trig_q   <= 1'b0;
         write_start_q   <= 1'b0;
         read_enable_q   <= 1'b0;
         read_start_q    <= 1'b0;
         reset_pattern_q <= `RST_BYTE;
      end else begin
         if (wr_access && paddr == `OFS_MAIN_CTRL) begin
            // Writing one to the status does nothing; zero disables
            if (!wbyte[`BIT_EW_ENABLED]) begin
               ew_enabled_q <= 1'b0;  // see [R14]
            end
            mode_q        <= wbyte[`MODE_MSB:`MODE_LSB];  // see [R13]
            enable_trig_q <= wbyte[`BIT_ENABLE_TRIG];
            write_start_q <= wbyte[`BIT_WRITE_START];  // see [R15]
            read_enable_q <= wbyte[`BIT_READ_ENABLE];
            read_start_q  <= wbyte[`BIT_READ_START];
         end else begin
            // Completions clear only when software is not writing the main control register
            if (flash_write_done) begin
               write_start_q <= 1'b0;  // see [R15]
            end
            if (flash_read_done) begin
               read_start_q <= 1'b0;
            end
            if (enable_timer_expired) begin
               enable_trig_q <= 1'b0;
            end
         end
         // Only the enable procedure may raise the status
         if (ew_enable_success) begin
            ew_enabled_q <= 1'b1;  // see [R14]
         end
         if (wr_access && paddr == `OFS_RESET_PATTERN) begin
            reset_pattern_q <= wbyte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data captured in the setup cycle, presented in the access cycle
   // Capturing early keeps pready tied high at the cost of showing the
   // state as it was at the end of the setup cycle; a hardware event in
   // the access cycle itself shows up on the next read.
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            `OFS_MAIN_CTRL: begin
               prdata[7:0] <= {ew_enabled_q, mode_q, enable_trig_q,
                               write_start_q, read_enable_q, read_start_q};
            end
            `OFS_RESET_PATTERN: begin
               prdata[7:0] <= reset_pattern_q;
            end
            `OFS_BUFFER_CTRL: begin
               // Bit stays high until the sweep has finished
               prdata[`BIT_BUFFER_CLEAR] <= clear_busy;  // see [R2]
            end
            `OFS_ADDR_LOW: begin
               prdata[7:0] <= address_low_byte;
            end
            `OFS_ADDR_HIGH: begin
               // Upper three bits read as zero
               prdata[7:0] <= {3'h0, address_high_byte};  // see [R10]
            end
            default: begin
               if (mapped && paddr >= `OFS_DATA0_LOW) begin
                  prdata[7:0] <= paddr[2] ? data_low_q[pair_of(paddr)]
                                          : data_high_q[pair_of(paddr)];
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs to the flash sequencing logic
   // All of these come straight from flip-flops, so the sequencer sees
   // glitch-free levels on the same clock.
   assign operation_mode_field       = mode_q;
   assign write_start_flag           = write_start_q;
   assign read_enable_bit            = read_enable_q;
   assign read_start_flag            = read_start_q;
   assign enable_procedure_trigger   = enable_trig_q;
   assign erase_write_enabled_status = ew_enabled_q;
   assign flash_address              = {address_high_byte, address_low_byte};
   assign page_select_bits           = flash_address[12:5];  // see [R4]
   assign reset_pattern_register     = reset_pattern_q;
   assign buffer_clear_busy          = clear_busy;

   // High byte of the first pair is read back through the data decode
   wire unused_first_high;
   assign unused_first_high = ^first_data_high_byte;

endmodule
`default_nettype wire

// File: iap_map.vh
`ifndef IAP_MAP_VH
`define IAP_MAP_VH

// Register byte offsets, one aligned 32-bit word each
`define OFS_MAIN_CTRL      12'h000
`define OFS_RESET_PATTERN  12'h004
`define OFS_BUFFER_CTRL    12'h008
`define OFS_ADDR_LOW       12'h00c
`define OFS_ADDR_HIGH      12'h010
`define OFS_DATA0_LOW      12'h014
`define OFS_DATA0_HIGH     12'h018
`define OFS_DATA1_LOW      12'h01c
`define OFS_DATA1_HIGH     12'h020
`define OFS_DATA2_LOW      12'h024
`define OFS_DATA2_HIGH     12'h028
`define OFS_DATA3_LOW      12'h02c
`define OFS_DATA3_HIGH     12'h030

// Main control register fields
`define BIT_EW_ENABLED     7
`define MODE_MSB           6
`define MODE_LSB           4
`define BIT_ENABLE_TRIG    3
`define BIT_WRITE_START    2
`define BIT_READ_ENABLE    1
`define BIT_READ_START     0

// Buffer control register field
`define BIT_BUFFER_CLEAR   0

// Operation mode codes
`define MODE_WRITE         3'h0
`define MODE_PAGE_ERASE    3'h1
`define MODE_READ          3'h3
`define MODE_EW_ENABLE     3'h6

// Reset values
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000

// Geometry
`define PAGE_WORDS         32
`define WORD_IDX_W         5
`define ADDR_HIGH_BITS     5
`define LAST_WORD_IDX      5'h1f

`endif

// File: write_page_buffer.v
`timescale 1ns/1ns
`default_nettype none
`include "iap_map.vh"

// One-page write buffer with a word-per-cycle clear sweep
module write_page_buffer #(
   parameter DEPTH   = `PAGE_WORDS,
   parameter IDX_W   = `WORD_IDX_W,
   parameter WORD_W  = 16
) (
   input  wire              ref_clk,
   input  wire              resetn,
   input  wire              load_valid,   // Store one word
   input  wire [IDX_W-1:0]  load_index,
   input  wire [WORD_W-1:0] load_word,
   input  wire              clear_start,  // Begin a clear sweep
   output wire              clear_busy,   // Sweep in progress
   input  wire [IDX_W-1:0]  rd_index,
   output reg  [WORD_W-1:0] rd_data
);

   reg [WORD_W-1:0] mem [0:DEPTH-1];    // Page contents
   reg              busy_q;             // Sweep running
   reg [IDX_W-1:0]  sweep_q;            // Word being cleared
   integer          i;

   assign clear_busy = busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // Sweep control; a new start restarts from word zero
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_q  <= 1'b0;
         sweep_q <= {IDX_W{1'b0}};
      end else if (clear_start) begin
         busy_q  <= 1'b1;
         sweep_q <= {IDX_W{1'b0}};
      end else if (busy_q) begin
         // Last word cleared ends the sweep
         if (sweep_q == DEPTH[IDX_W-1:0] - 1'b1) begin
            busy_q <= 1'b0;
         end
         sweep_q <= sweep_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage: array reset at power-on, then sweep or load
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= {WORD_W{1'b0}};
         end
      end else begin
         // Sweep first so a load to the same word in the same cycle wins
         if (busy_q) begin
            mem[sweep_q] <= {WORD_W{1'b0}};
         end
         if (load_valid) begin
            mem[load_index] <= load_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered read port towards the flash programming logic
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= {WORD_W{1'b0}};
      end else begin
         rd_data <= mem[rd_index];
      end
   end

endmodule
`default_nettype wire

// File: iap_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "iap_map.vh"
// Port-level checks of the flash write buffer register block
module iap_regs_props #(
   parameter AW = 12
) (
   input wire logic          ref_clk,
   input wire logic          resetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0]   pwdata,
   input wire logic          pslverr,
   input wire logic          ew_enable_success,
   input wire logic          flash_write_done,
   input wire logic          write_start_flag,
   input wire logic          erase_write_enabled_status,
   input wire logic [7:0]    page_select_bits,
   input wire logic [12:0]   flash_address,
   input wire logic          buffer_clear_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////
   logic acc_wr;   // Write accepted in the access phase
   logic hi_wr;    // Word commit through the first high data byte
   logic main_wr;  // Software write to the main control register
   assign acc_wr  = psel && penable && pwrite;
   assign hi_wr   = acc_wr && paddr == `OFS_DATA0_HIGH;
   assign main_wr = acc_wr && paddr == `OFS_MAIN_CTRL;
   ////////////////////////////////////////////////////////////////////////
   chk_page_map: assert property (
      page_select_bits == flash_address[12:5]) else $error("page bits differ from address");
   chk_tag_step: assert property (
      hi_wr && flash_address[4:0] != 5'h1f |=> flash_address == $past(flash_address) + 13'h0001)
      else $error("address did not step after word commit");
   chk_tag_hold: assert property (
      hi_wr && flash_address[4:0] == 5'h1f |=> $stable(flash_address)) else $error("address left page end");
   chk_high_addr: assert property (
      acc_wr && paddr == `OFS_ADDR_HIGH |=> flash_address[12:8] == $past(pwdata[4:0]))
      else $error("high address bits not stored");
   chk_clear_start: assert property (
      acc_wr && paddr == `OFS_BUFFER_CTRL && pwdata[0] |=> buffer_clear_busy[*8])
      else $error("clear sweep did not start");
   chk_done_clear: assert property (
      flash_write_done |=> buffer_clear_busy) else $error("finished write left buffer uncleared");
   chk_start_drop: assert property (
      flash_write_done && !main_wr |=> !write_start_flag) else $error("write start not dropped");
   chk_status_set: assert property (
      ew_enable_success |=> erase_write_enabled_status) else $error("enabled status not set");
   chk_status_sw: assert property (
      main_wr && !ew_enable_success && !erase_write_enabled_status |=> !erase_write_enabled_status)
      else $error("software set enabled status");
   chk_unmapped_err: assert property (
      psel && penable && paddr > 'h30 |-> pslverr) else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// File: iap_flash_write_buffer_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "iap_map.vh"
// Register-level bench for the flash write buffer block
module iap_flash_write_buffer_regs_tb;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0]  pulse_q = 4'h0;       // Success, timer, write done, read done
   logic [4:0]  buf_rd_index = 5'h00;
   wire  [31:0] prdata;
   wire         pready, pslverr, write_start_flag, read_enable_bit, read_start_flag;
   wire         enable_procedure_trigger, erase_write_enabled_status, buffer_clear_busy;
   wire  [15:0] buf_rd_data;
   wire  [2:0]  operation_mode_field;
   wire  [7:0]  page_select_bits, reset_pattern_register;
   wire  [12:0] flash_address;
   logic [31:0] rd;                   // Last read data
   logic        err_q;                // Last error response
   int          n_fail = 0, checks_done = 0;
   iap_flash_write_buffer_regs #(.AW(12)) iap_flash_write_buffer_regs_inst (.ref_clk(ref_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ew_enable_success(pulse_q[0]), .enable_timer_expired(pulse_q[1]),
      .flash_write_done(pulse_q[2]), .flash_read_done(pulse_q[3]), .buf_rd_index(buf_rd_index),
      .buf_rd_data(buf_rd_data), .operation_mode_field(operation_mode_field), .write_start_flag(write_start_flag),
      .read_enable_bit(read_enable_bit), .read_start_flag(read_start_flag),
      .enable_procedure_trigger(enable_procedure_trigger), .erase_write_enabled_status(erase_write_enabled_status),
      .page_select_bits(page_select_bits), .flash_address(flash_address),
      .reset_pattern_register(reset_pattern_register), .buffer_clear_busy(buffer_clear_busy));
   initial forever #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, entered just after an edge; an idle edge follows so psel never toggles twice at once
   task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int i;
      i = 0;
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, d};
      @(posedge ref_clk); penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
         i++;
         if (i > 50) begin n_fail++; print_verdict(); end
         @(posedge ref_clk);
      end
      rd = prdata; err_q = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // One-cycle strobe on the sequencing inputs
   task pulse(input logic [3:0] m);
      pulse_q <= m; @(posedge ref_clk); pulse_q <= 4'h0; @(posedge ref_clk);
   endtask
   // Buffer read port has one cycle of latency
   task buf_chk(input logic [4:0] idx, input logic [15:0] exp);
      buf_rd_index <= idx; @(posedge ref_clk); @(posedge ref_clk);
      check(buf_rd_data, exp);
   endtask
   task wait_clear;
      int i;
      for (i = 0; buffer_clear_busy !== 1'b0; i++) begin
         if (i > 100) begin n_fail++; print_verdict(); end
         @(posedge ref_clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_map;
      for (int i = 0; i <= 12; i++) begin apb(1'b0, 12'(i * 4), 8'h00); check(rd, 0); end
      apb(1'b1, 12'h034, 8'h77); check(err_q, 1); apb(1'b0, 12'h034, 8'h00); check(rd, 0);
      apb(1'b1, `OFS_ADDR_HIGH, 8'hff); apb(1'b0, `OFS_ADDR_HIGH, 8'h00); check(rd, 32'h1f);
      for (int i = 5; i <= 12; i++) begin
         apb(1'b1, 12'(i * 4), 8'(8'h5a ^ i)); apb(1'b0, 12'(i * 4), 8'h00); check(rd, 8'h5a ^ i);
      end
      apb(1'b1, `OFS_RESET_PATTERN, 8'ha5); check(reset_pattern_register, 8'ha5);
   endtask
   task t_modes;
      logic [2:0] codes [4] = '{`MODE_WRITE, `MODE_PAGE_ERASE, `MODE_READ, `MODE_EW_ENABLE};
      foreach (codes[i]) begin
         apb(1'b1, `OFS_MAIN_CTRL, {1'b0, codes[i], 4'h0}); check(operation_mode_field, codes[i]);
      end
   endtask
   task t_enable;
      apb(1'b1, `OFS_MAIN_CTRL, 8'h80); check(erase_write_enabled_status, 0);
      apb(1'b1, `OFS_ADDR_HIGH, 8'h00); apb(1'b1, `OFS_ADDR_LOW, 8'h00);
      apb(1'b1, `OFS_DATA0_LOW, 8'h11); apb(1'b1, `OFS_DATA0_HIGH, 8'h22);
      buf_chk(5'h00, 16'h0000);
      pulse(4'h1); check(erase_write_enabled_status, 1);
      apb(1'b1, `OFS_MAIN_CTRL, 8'h00); check(erase_write_enabled_status, 0);
      pulse(4'h1);
   endtask
   // Fill the last two words of a page, then run into the page end
   task t_load;
      apb(1'b1, `OFS_BUFFER_CTRL, 8'h01); wait_clear();
      apb(1'b1, `OFS_ADDR_HIGH, 8'h03); apb(1'b1, `OFS_ADDR_LOW, 8'h1e);
      check(page_select_bits, 8'h18);
      apb(1'b1, `OFS_DATA0_LOW, 8'h34); buf_chk(5'h1e, 16'h0000);
      apb(1'b1, `OFS_DATA0_HIGH, 8'h12); check(flash_address, 13'h031f);
      buf_chk(5'h1e, 16'h1234);
      apb(1'b1, `OFS_DATA0_LOW, 8'h78); apb(1'b1, `OFS_DATA0_HIGH, 8'h56);
      check(flash_address, 13'h031f); buf_chk(5'h1f, 16'h5678);
   endtask
   task t_clear;
      apb(1'b1, `OFS_BUFFER_CTRL, 8'h01); apb(1'b0, `OFS_BUFFER_CTRL, 8'h00); check(rd, 1);
      wait_clear(); apb(1'b0, `OFS_BUFFER_CTRL, 8'h00); check(rd, 0);
      buf_chk(5'h1e, 16'h0000); buf_chk(5'h1f, 16'h0000);
   endtask
   task t_write;
      apb(1'b1, `OFS_ADDR_LOW, 8'h05); apb(1'b1, `OFS_DATA0_HIGH, 8'h9a);
      buf_chk(5'h05, 16'h9a78);
      apb(1'b1, `OFS_MAIN_CTRL, 8'h84); check(write_start_flag, 1);
      check(erase_write_enabled_status, 1);
      pulse(4'h4); check(write_start_flag, 0); check(buffer_clear_busy, 1);
      wait_clear(); buf_chk(5'h05, 16'h0000);
   endtask
   task t_misc;
      apb(1'b1, `OFS_MAIN_CTRL, 8'h8a); check(read_enable_bit, 1); check(enable_procedure_trigger, 1);
      pulse(4'h2); check(enable_procedure_trigger, 0);
      apb(1'b1, `OFS_MAIN_CTRL, 8'h81); check(read_start_flag, 1);
      pulse(4'h8); check(read_start_flag, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_map(); t_modes(); t_enable(); t_load(); t_clear(); t_write(); t_misc();
      print_verdict();
   end
endmodule
bind iap_flash_write_buffer_regs iap_regs_props #(.AW(AW)) props_inst (.ref_clk(ref_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .ew_enable_success(ew_enable_success), .flash_write_done(flash_write_done),
   .write_start_flag(write_start_flag), .erase_write_enabled_status(erase_write_enabled_status),
   .page_select_bits(page_select_bits), .flash_address(flash_address), .buffer_clear_busy(buffer_clear_busy));
`default_nettype wire
